/* File: rtl/irq_ctrl_pkg.sv */
// Constants shared by the interrupt enable and priority block
package irq_ctrl_pkg;

  // ==========================================================
  // Register addresses in special-function space
  localparam logic [7:0] ENABLE_MASK_ADDR = 8'ha8;
  localparam logic [7:0] LEVEL_SELECT_ADDR = 8'hb8;
  // Bit addresses: register address plus bit number
  localparam logic [4:0] BIT_ADDR_BASE_MSB = 5'h15;
  localparam logic [4:0] LEVEL_BIT_BASE_MSB = 5'h17;

  // ==========================================================
  // Reset values
  localparam logic [7:0] ENABLE_MASK_RESET = 8'h00;
  localparam logic [7:0] LEVEL_SELECT_RESET = 8'h80;
  localparam logic [7:0] LEVEL_SELECT_FIXED = 8'h80;

  // ==========================================================
  // Field positions
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int SERIAL_PERIPH_BIT = 6;
  localparam int TIMER2_BIT = 5;
  localparam int UART0_BIT = 4;
  localparam int TIMER1_BIT = 3;
  localparam int EXT1_BIT = 2;
  localparam int TIMER0_BIT = 1;
  localparam int EXT0_BIT = 0;

  // ==========================================================
  // Sources, in fixed service order (index 0 served first)
  localparam int NUM_SOURCES = 7;
  localparam int SRC_IDX_W = 3;

  typedef enum logic [1:0] {
    SVC_IDLE,
    SVC_LOW,
    SVC_HIGH,
    SVC_HIGH_OVER_LOW
  } svc_state_t;

endpackage

/* File: rtl/irq_enable_priority.sv */
// Interrupt enable and priority registers with request arbitration
//
// Contract
// - Global enable bit 7 gates every source; cleared means no request at all.
// - With global enable set, each source requests only if its own mask is set.
// - Enable bit 6 masks the serial peripheral interrupt.
// - Enable bit 5 masks timer 2, raised by either overflow flag.
// - Enable bit 4 masks the UART0 interrupt.
// - Enable bit 3 masks timer 1, raised by its overflow flag.
// - Enable bit 2 masks external request 1.
// - Enable bit 1 masks timer 0, raised by its overflow flag.
// - Enable bit 0 masks external request 0.
// - Level bit 2 sets the level of external request 1.
// - Level bit 1 sets the level of timer 0.
// - Level bit 0 sets the level of external request 0; 1 is high.
// - A level bit of 0 means low priority.
// - Enable register at 0xA8 on all pages, bit-writable.
// - Level register at 0xB8 on all pages, bit-addressable.
// - High preempts low service; nothing preempts high service.
// - Higher level first; fixed source order among equals.
// - Pending requests sampled and decoded every clock.
`timescale 1ns/1ps
`default_nettype none

module irq_enable_priority
  import irq_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Byte access to special-function space
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_rvalid,
  // Single-bit access
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wr,
  input wire logic i_bit_rd,
  input wire logic i_bit_wdata,
  output logic o_bit_rdata,
  output logic o_bit_rvalid,
  // Interrupt-pending flags from the sources
  input wire logic i_ext_request0_pin,
  input wire logic i_timer0_overflow_flag,
  input wire logic i_ext_request1_pin,
  input wire logic i_timer1_overflow_flag,
  input wire logic i_uart0_req,
  input wire logic i_timer2_low_overflow_flag,
  input wire logic i_timer2_high_overflow_flag,
  input wire logic i_serial_periph_req,
  // Sequencer handshake
  output logic o_irq_req,
  output logic [SRC_IDX_W-1:0] o_irq_index,
  output logic o_irq_high,
  input wire logic i_irq_ack,
  input wire logic i_irq_return,
  output logic [1:0] o_in_service
);

  // ==========================================================
  // Registers
  logic [7:0] enable_mask_r;
  logic [7:0] level_select_r;
  svc_state_t svc_r;
  svc_state_t svc_nxt;

  logic global_irq_enable;
  logic serial_periph_irq_enable;
  logic timer2_irq_enable;
  logic uart0_irq_enable;
  logic timer1_irq_enable;
  logic ext1_irq_enable;
  logic timer0_irq_enable;
  logic ext0_irq_enable;

  logic serial_periph_level;
  logic timer2_level;
  logic uart0_level;
  logic timer1_level;
  logic ext1_level;
  logic timer0_level;
  logic ext0_level;

  assign global_irq_enable = enable_mask_r[GLOBAL_IRQ_ENABLE_BIT];
  assign serial_periph_irq_enable = enable_mask_r[SERIAL_PERIPH_BIT];
  assign timer2_irq_enable = enable_mask_r[TIMER2_BIT];
  assign uart0_irq_enable = enable_mask_r[UART0_BIT];
  assign timer1_irq_enable = enable_mask_r[TIMER1_BIT];
  assign ext1_irq_enable = enable_mask_r[EXT1_BIT];
  assign timer0_irq_enable = enable_mask_r[TIMER0_BIT];
  assign ext0_irq_enable = enable_mask_r[EXT0_BIT];

  assign serial_periph_level = level_select_r[SERIAL_PERIPH_BIT];
  assign timer2_level = level_select_r[TIMER2_BIT];
  assign uart0_level = level_select_r[UART0_BIT];
  assign timer1_level = level_select_r[TIMER1_BIT];
  assign ext1_level = level_select_r[EXT1_BIT];
  assign timer0_level = level_select_r[TIMER0_BIT];
  assign ext0_level = level_select_r[EXT0_BIT];

  // ==========================================================
  // Address decode
  // No page input: both registers answer on every page
  logic enable_byte_hit;
  logic level_byte_hit;
  logic enable_bit_hit;
  logic level_bit_hit;
  logic [2:0] bit_num;

  assign enable_byte_hit = (i_sfr_addr == ENABLE_MASK_ADDR);
  assign level_byte_hit = (i_sfr_addr == LEVEL_SELECT_ADDR);
  assign enable_bit_hit = (i_bit_addr[7:3] == BIT_ADDR_BASE_MSB);
  assign level_bit_hit = (i_bit_addr[7:3] == LEVEL_BIT_BASE_MSB);
  assign bit_num = i_bit_addr[2:0];

  // ==========================================================
  // Enable register writes
  // Bit write after byte write in the same cycle: bit write wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_mask_r <= ENABLE_MASK_RESET;
    end else begin
      if (i_sfr_wr && enable_byte_hit) begin
        enable_mask_r <= i_sfr_wdata;
      end
      if (i_bit_wr && enable_bit_hit) begin
        enable_mask_r[bit_num] <= i_bit_wdata;
      end
    end
  end

  // ==========================================================
  // Level register writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_select_r <= LEVEL_SELECT_RESET;
    end else begin
      if (i_sfr_wr && level_byte_hit) begin
        level_select_r <= i_sfr_wdata | LEVEL_SELECT_FIXED;
      end
      if (i_bit_wr && level_bit_hit && !LEVEL_SELECT_FIXED[bit_num]) begin
        level_select_r[bit_num] <= i_bit_wdata;
      end
    end
  end

  // ==========================================================
  // Read path, answered one clock after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
      o_sfr_rvalid <= 1'b0;
    end else begin
      o_sfr_rvalid <= i_sfr_rd && (enable_byte_hit || level_byte_hit);
      if (i_sfr_rd && enable_byte_hit) begin
        o_sfr_rdata <= enable_mask_r;
      end else if (i_sfr_rd && level_byte_hit) begin
        o_sfr_rdata <= level_select_r | LEVEL_SELECT_FIXED;
      end else begin
        o_sfr_rdata <= 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bit_rdata <= 1'b0;
      o_bit_rvalid <= 1'b0;
    end else begin
      o_bit_rvalid <= i_bit_rd && (enable_bit_hit || level_bit_hit);
      if (i_bit_rd && enable_bit_hit) begin
        o_bit_rdata <= enable_mask_r[bit_num];
      end else if (i_bit_rd && level_bit_hit) begin
        o_bit_rdata <= level_select_r[bit_num] | LEVEL_SELECT_FIXED[bit_num];
      end else begin
        o_bit_rdata <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Masking
  logic [NUM_SOURCES-1:0] raw_req;
  logic [NUM_SOURCES-1:0] src_enable;
  logic [NUM_SOURCES-1:0] masked_req;
  logic [NUM_SOURCES-1:0] src_level;

  always_comb begin
    raw_req = '0;
    src_enable = '0;
    raw_req[EXT0_BIT] = i_ext_request0_pin;
    src_enable[EXT0_BIT] = ext0_irq_enable;
    raw_req[TIMER0_BIT] = i_timer0_overflow_flag;
    src_enable[TIMER0_BIT] = timer0_irq_enable;
    raw_req[EXT1_BIT] = i_ext_request1_pin;
    src_enable[EXT1_BIT] = ext1_irq_enable;
    raw_req[TIMER1_BIT] = i_timer1_overflow_flag;
    src_enable[TIMER1_BIT] = timer1_irq_enable;
    raw_req[UART0_BIT] = i_uart0_req;
    src_enable[UART0_BIT] = uart0_irq_enable;
    raw_req[TIMER2_BIT] = i_timer2_low_overflow_flag | i_timer2_high_overflow_flag;
    src_enable[TIMER2_BIT] = timer2_irq_enable;
    raw_req[SERIAL_PERIPH_BIT] = i_serial_periph_req;
    src_enable[SERIAL_PERIPH_BIT] = serial_periph_irq_enable;
  end

  assign masked_req = global_irq_enable ? (raw_req & src_enable) : '0;

  assign src_level = {serial_periph_level, timer2_level, uart0_level, timer1_level,
                      ext1_level, timer0_level, ext0_level};

  // ==========================================================
  // Service nesting
  // Return first, then ack, so an ack in the same cycle is kept
  always_comb begin
    svc_nxt = svc_r;
    if (i_irq_return) begin
      case (svc_r)
        SVC_LOW: svc_nxt = SVC_IDLE;
        SVC_HIGH: svc_nxt = SVC_IDLE;
        SVC_HIGH_OVER_LOW: svc_nxt = SVC_LOW;
        default: svc_nxt = SVC_IDLE;
      endcase
    end
    if (i_irq_ack && o_irq_req) begin
      case (svc_nxt)
        SVC_IDLE: svc_nxt = o_irq_high ? SVC_HIGH : SVC_LOW;
        SVC_LOW: svc_nxt = o_irq_high ? SVC_HIGH_OVER_LOW : SVC_LOW;
        default: svc_nxt = svc_nxt;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      svc_r <= SVC_IDLE;
    end else begin
      svc_r <= svc_nxt;
    end
  end

  // ==========================================================
  // Arbitration
  logic low_allowed;
  logic high_allowed;
  logic pick_valid;
  logic [SRC_IDX_W-1:0] pick_index;
  logic pick_high;

  // Nothing preempts high; only high preempts low
  assign low_allowed = (svc_nxt == SVC_IDLE);
  assign high_allowed = (svc_nxt == SVC_IDLE) || (svc_nxt == SVC_LOW);

  irq_pick #(
    .N_SRC(NUM_SOURCES)
  ) u_pick (
    .i_pending(masked_req),
    .i_level(src_level),
    .i_low_allowed(low_allowed),
    .i_high_allowed(high_allowed),
    .o_valid(pick_valid),
    .o_index(pick_index),
    .o_high(pick_high)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq_req <= 1'b0;
      o_irq_index <= '0;
      o_irq_high <= 1'b0;
    end else begin
      o_irq_req <= pick_valid;
      o_irq_index <= pick_index;
      o_irq_high <= pick_high;
    end
  end

  always_comb begin
    case (svc_r)
      SVC_LOW: o_in_service = 2'b01;
      SVC_HIGH: o_in_service = 2'b10;
      SVC_HIGH_OVER_LOW: o_in_service = 2'b11;
      default: o_in_service = 2'b00;
    endcase
  end

endmodule

`default_nettype wire

/* File: rtl/irq_pick.sv */
// Picks the source to serve from masked pending requests and their levels
`timescale 1ns/1ps
`default_nettype none

module irq_pick
  import irq_ctrl_pkg::*;
#(
  parameter int N_SRC = NUM_SOURCES
) (
  input wire logic [N_SRC-1:0] i_pending,
  input wire logic [N_SRC-1:0] i_level,
  input wire logic i_low_allowed,
  input wire logic i_high_allowed,
  output logic o_valid,
  output logic [SRC_IDX_W-1:0] o_index,
  output logic o_high
);

  // ==========================================================
  // Lowest set bit wins: fixed order among equal levels
  function automatic logic [SRC_IDX_W-1:0] first_set(input logic [N_SRC-1:0] v);
    logic [SRC_IDX_W-1:0] idx;
    idx = '0;
    for (int k = N_SRC - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = SRC_IDX_W'(k);
      end
    end
    return idx;
  endfunction

  logic [N_SRC-1:0] high_req;
  logic [N_SRC-1:0] low_req;

  assign high_req = i_high_allowed ? (i_pending & i_level) : '0;
  assign low_req = i_low_allowed ? (i_pending & ~i_level) : '0;

  // ==========================================================
  // Higher level first
  always_comb begin
    o_valid = 1'b0;
    o_high = 1'b0;
    o_index = '0;
    if (|high_req) begin
      o_valid = 1'b1;
      o_high = 1'b1;
      o_index = first_set(high_req);
    end else if (|low_req) begin
      o_valid = 1'b1;
      o_index = first_set(low_req);
    end
  end

endmodule

`default_nettype wire

/* File: verification/core_seq_model.sv */
// Interrupt sequencer of the core: takes offered requests, signals returns
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic i_take,
  input wire logic i_finish,
  output logic o_ack,
  output logic o_ret
);
  // ==========================================================
  // Falling edge drive, so the rising edge sees settled pulses
  always_ff @(negedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      o_ret <= 1'b0;
    end else begin
      o_ack <= i_take && i_req && !o_ack;
      o_ret <= i_finish && !o_ret;
    end
  end
endmodule
`default_nettype wire

/* File: verification/irq_ep_assertions.sv */
// Port-level checks for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
module irq_ep_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_rvalid,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wr,
  input wire logic i_bit_rd,
  input wire logic o_bit_rvalid,
  input wire logic o_irq_req,
  input wire logic o_irq_high,
  input wire logic i_irq_ack,
  input wire logic i_irq_return,
  input wire logic [1:0] o_in_service
);
  // ==========================================================
  // Clocking and helpers
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic sfr_hit;
  logic bit_hit;
  assign sfr_hit = i_sfr_addr == 8'ha8 || i_sfr_addr == 8'hb8;
  assign bit_hit = i_bit_addr[7:3] == 5'h15 || i_bit_addr[7:3] == 5'h17;
  // ==========================================================
  // Properties
  chk_rd_answer: assert property (i_sfr_rd && sfr_hit |=> o_sfr_rvalid)
    else $error("byte read hit not answered");
  chk_rd_quiet: assert property (!(i_sfr_rd && sfr_hit) |=> !o_sfr_rvalid && o_sfr_rdata == 8'h00)
    else $error("byte read answer without hit");
  chk_level_top: assert property (i_sfr_rd && i_sfr_addr == 8'hb8 |=> o_sfr_rdata[7])
    else $error("level bit 7 read as 0");
  chk_bit_answer: assert property (i_bit_rd && bit_hit |=> o_bit_rvalid)
    else $error("bit read hit not answered");
  // Two edges: one for the register, one for the decode
  chk_global_off: assert property (i_sfr_wr && i_sfr_addr == 8'ha8 && !i_sfr_wdata[7] && !i_bit_wr
    ##1 !(i_sfr_wr || i_bit_wr) |=> !o_irq_req)
    else $error("request with global enable clear");
  chk_high_blocks: assert property (o_in_service[1] |-> !o_irq_req)
    else $error("request offered during high service");
  chk_low_gate: assert property (o_in_service == 2'b01 && o_irq_req |-> o_irq_high)
    else $error("low request offered during low service");
  chk_ack_low: assert property (i_irq_ack && o_irq_req && !o_irq_high && !i_irq_return
    && o_in_service == 2'b00 |=> o_in_service == 2'b01)
    else $error("low ack did not enter service");
  chk_ack_nest: assert property (i_irq_ack && o_irq_req && !i_irq_return
    && o_in_service == 2'b01 |=> o_in_service == 2'b11)
    else $error("high ack did not nest");
  chk_ret_pop: assert property (i_irq_return && !i_irq_ack && o_in_service == 2'b11
    |=> o_in_service == 2'b01)
    else $error("return did not pop high first");
endmodule
bind irq_enable_priority irq_ep_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
  .o_sfr_rdata(o_sfr_rdata), .o_sfr_rvalid(o_sfr_rvalid), .i_bit_addr(i_bit_addr),
  .i_bit_wr(i_bit_wr), .i_bit_rd(i_bit_rd), .o_bit_rvalid(o_bit_rvalid), .o_irq_req(o_irq_req),
  .o_irq_high(o_irq_high), .i_irq_ack(i_irq_ack), .i_irq_return(i_irq_return),
  .o_in_service(o_in_service));
`default_nettype wire

/* File: verification/test_interrupt_enable_priority.sv */
// Register and arbitration tests for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_enable_priority;
  import irq_ctrl_pkg::*;
  logic i_clk, i_rst_n, sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, take, finish;
  logic [7:0] sfr_addr, sfr_wdata, bit_addr, flg, rdata, m;
  logic rvalid, brdata, brvalid, req, high, ack, ret;
  logic [2:0] idx;
  logic [1:0] insvc;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  irq_enable_priority DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sfr_addr(sfr_addr),
    .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(rdata),
    .o_sfr_rvalid(rvalid), .i_bit_addr(bit_addr), .i_bit_wr(bit_wr), .i_bit_rd(bit_rd),
    .i_bit_wdata(bit_wdata), .o_bit_rdata(brdata), .o_bit_rvalid(brvalid),
    .i_ext_request0_pin(flg[0]), .i_timer0_overflow_flag(flg[1]), .i_ext_request1_pin(flg[2]),
    .i_timer1_overflow_flag(flg[3]), .i_uart0_req(flg[4]), .i_timer2_low_overflow_flag(flg[5]),
    .i_serial_periph_req(flg[6]), .i_timer2_high_overflow_flag(flg[7]), .o_irq_req(req),
    .o_irq_index(idx), .o_irq_high(high), .i_irq_ack(ack), .i_irq_return(ret),
    .o_in_service(insvc));
  core_seq_model u_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_take(take),
    .i_finish(finish), .o_ack(ack), .o_ret(ret));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // ==========================================================
  // Tasks
  task wrap_up;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge i_clk);
    sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input logic v);
    @(negedge i_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge i_clk);
    sfr_rd = 1'b0;
    chk({7'h00, rvalid}, {7'h00, v});
    chk(rdata, e);
  endtask
  task bwr(input logic [7:0] a, input logic v);
    @(negedge i_clk);
    bit_addr = a;
    bit_wdata = v;
    bit_wr = 1'b1;
    @(negedge i_clk);
    bit_wr = 1'b0;
  endtask
  task brd(input logic [7:0] a, input logic e);
    @(negedge i_clk);
    bit_addr = a;
    bit_rd = 1'b1;
    @(negedge i_clk);
    bit_rd = 1'b0;
    chk({6'h00, brvalid, brdata}, {6'h00, 1'b1, e});
  endtask
  task look(input logic r, input logic [2:0] i, input logic h);
    chk({7'h00, req}, {7'h00, r});
    if (r) chk({4'h0, idx, high}, {4'h0, i, h});
  endtask
  task irq(input logic [7:0] en, input logic [7:0] lv, input logic [7:0] fl,
           input logic r, input logic [2:0] i, input logic h);
    wr(8'ha8, en);
    wr(8'hb8, lv);
    flg = fl;
    repeat (2) @(negedge i_clk);
    look(r, i, h);
  endtask
  // Commands go out on the rising edge so the model reads them settled
  task core(input logic t);
    @(posedge i_clk);
    if (t) take <= 1'b1;
    else finish <= 1'b1;
    @(posedge i_clk);
    take <= 1'b0;
    finish <= 1'b0;
    repeat (2) @(negedge i_clk);
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    {sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, take, finish} = 7'h00;
    {sfr_addr, sfr_wdata, bit_addr, flg} = 32'h0000_0000;
    i_rst_n = 1'b0;
    repeat (8) @(negedge i_clk);
    i_rst_n = 1'b1;
    rd(8'ha8, 8'h00, 1'b1);
    rd(8'hb8, 8'h80, 1'b1);
    wr(8'hb8, 8'h00);
    rd(8'hb8, 8'h80, 1'b1);
    rd(8'h00, 8'h00, 1'b0);
    bwr(8'haf, 1'b1);
    rd(8'ha8, 8'h80, 1'b1);
    bwr(8'hbf, 1'b0);
    brd(8'hbf, 1'b1);
    bwr(8'hb9, 1'b1);
    brd(8'hb9, 1'b1);
    brd(8'hb8, 1'b0);
    for (int i = 0; i < 7; i++) begin
      m = 8'h01 << i;
      irq(8'h80 | m, 8'h80, m, 1'b1, i[2:0], 1'b0);
      irq(m, 8'h80, m, 1'b0, 3'h0, 1'b0);
      // Global enable on, own mask off
      irq(8'hff & ~m, 8'h80, m, 1'b0, 3'h0, 1'b0);
      irq(8'hff, 8'h80 | m, 8'h7f, 1'b1, i[2:0], 1'b1);
    end
    irq(8'ha0, 8'h80, 8'h80, 1'b1, 3'h5, 1'b0);
    irq(8'hff, 8'h80, 8'h7e, 1'b1, 3'h1, 1'b0);
    irq(8'hff, 8'h84, 8'h02, 1'b1, 3'h1, 1'b0);
    core(1'b1);
    chk({6'h00, insvc}, 8'h01);
    look(1'b0, 3'h0, 1'b0);
    flg = 8'h06;
    repeat (2) @(negedge i_clk);
    look(1'b1, 3'h2, 1'b1);
    core(1'b1);
    chk({6'h00, insvc}, 8'h03);
    look(1'b0, 3'h0, 1'b0);
    core(1'b0);
    chk({6'h00, insvc}, 8'h01);
    look(1'b1, 3'h2, 1'b1);
    core(1'b0);
    chk({6'h00, insvc}, 8'h00);
    look(1'b1, 3'h2, 1'b1);
    // Return while idle is ignored
    core(1'b0);
    chk({6'h00, insvc}, 8'h00);
    // Mid-run reset brings back the reset values
    @(negedge i_clk);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    rd(8'ha8, 8'h00, 1'b1);
    rd(8'hb8, 8'h80, 1'b1);
    chk({6'h00, insvc}, 8'h00);
    look(1'b0, 3'h0, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
